// *** hdl/safety_stop_pkg.sv ***
// constants and carrier types for the safety stop sequencer
// assumes a single 20 MHz clock and an AHB-Lite register slave
package safety_stop_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] CFG_OFS     = 8'h04;
   localparam logic [7:0] DELAY1_OFS  = 8'h08;
   localparam logic [7:0] DELAY2_OFS  = 8'h0C;
   localparam logic [7:0] STATUS_OFS  = 8'h10;
   localparam logic [7:0] IRQ_STS_OFS = 8'h14;
   localparam logic [7:0] IRQ_MSK_OFS = 8'h18;

   // control register fields
   localparam int CTRL_ACTIVATE_BIT = 0;
   localparam int CTRL_SWSTOP_BIT   = 1;

   // config field positions, two bits of category each
   localparam int CFG_EMS_PEND_POS = 0;
   localparam int CFG_EMS_EXT_POS  = 2;
   localparam int CFG_PROT_POS     = 4;
   localparam int CFG_LIM_POS      = 6;

   // category codes
   localparam logic [1:0] CAT0    = 2'h0;
   localparam logic [1:0] CAT1    = 2'h1;
   localparam logic [1:0] CAT2    = 2'h2;
   localparam logic [1:0] CAT_NONE = 2'h3;

   // reset values: emergency and protective cat1, limits cat1
   localparam logic [7:0] CFG_RESET = 8'h55;

   // default stop delays in microseconds, and cycles at 20 MHz
   localparam int CLK_HZ          = 20_000_000;
   localparam int DELAY1_US       = 500;
   localparam int DELAY2_US       = 500;
   localparam logic [31:0] DELAY1_RESET = 32'(DELAY1_US * (CLK_HZ / 1_000_000));
   localparam logic [31:0] DELAY2_RESET = 32'(DELAY2_US * (CLK_HZ / 1_000_000));

   // interrupt event bits
   localparam int IRQ_CAT0_BIT  = 0;
   localparam int IRQ_CAT1_BIT  = 1;
   localparam int IRQ_CAT2_BIT  = 2;
   localparam int IRQ_ESCAL_BIT = 3;
   localparam int IRQ_W         = 4;

   // stop sequencer states
   typedef enum logic [2:0] {
      ST_OFF, ST_RUN, ST_DECEL1, ST_DECEL2, ST_HOLD
   } stop_state_e;

   // safety inputs grouped together
   typedef struct packed {
      logic faultDetected;
      logic pendantEmergencyInput;
      logic externalEmergencyInput;
      logic protectiveStopInput;
      logic hardGuardInput;
      logic softGuardInput;
      logic limitViolation;
      logic positionChanged;
   } safety_in_s;

   // drive commands grouped together
   typedef struct packed {
      logic motorPowerEn;
      logic decelCmd;
      logic holdSupervision;
      logic motionAllowed;
   } drive_out_s;

endpackage

// *** hdl/stop_delay_timer.sv ***
// down-counter timing the deceleration phase of timed stops
// assumes load and the count value are synchronous to ref_clk
`timescale 1ns/1ps
module stop_delay_timer
   import safety_stop_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // control
   input  wire logic        load,
   input  wire logic [31:0] loadValue,
   // status
   output logic             expired
);

   logic [31:0] count_r;

   // a zero delay still takes one cycle to expire
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         count_r <= 32'h0;
      end else if (load) begin
         count_r <= (loadValue == 32'h0) ? 32'h1 : loadValue;
      end else if (count_r != 32'h0) begin
         count_r <= count_r - 32'h1;
      end
   end

   assign expired = (count_r == 32'h1) && !load;

endmodule

// *** hdl/ahb_reg_slave.sv ***
// AHB-Lite front end: latches the address phase, yields write strobes
// assumes single word transfers; always OKAY, zero wait states
`timescale 1ns/1ps
module ahb_reg_slave
   import safety_stop_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // AHB-Lite
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   // register side
   output logic             wrEn,
   output logic             rdEn,
   output logic [7:0]       regAddr
);

   logic       pendWr_r;
   logic       pendRd_r;
   logic [7:0] addr_r;

   // capture address phase when the bus advances
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pendWr_r <= 1'b0;
         pendRd_r <= 1'b0;
         addr_r   <= 8'h0;
      end else if (hready) begin
         pendWr_r <= hsel && htrans[1] && hwrite;
         pendRd_r <= hsel && htrans[1] && !hwrite;
         addr_r   <= haddr[7:0];
      end
   end

   assign wrEn    = pendWr_r;
   assign rdEn    = pendRd_r;
   assign regAddr = addr_r;

endmodule

// *** hdl/safety_stop_category_controller.sv ***
// safety stop sequencer: picks stop category, drives power, decel, hold
// assumes safety inputs are already debounced and synchronous to ref_clk
`timescale 1ns/1ps
module safety_stop_category_controller
   import safety_stop_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // safety inputs
   input  wire safety_in_s  safetyIn,
   // drive commands
   output drive_out_s       driveOut,
   // interrupt
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // register slave

   logic        wrEn;
   logic        rdEn;
   logic [7:0]  regAddr;

   // address phase is latched here; writes land at the end of the data phase
   ahb_reg_slave u_bus (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .hsel    (hsel),
      .haddr   (haddr),
      .htrans  (htrans),
      .hwrite  (hwrite),
      .hready  (hready),
      .wrEn    (wrEn),
      .rdEn    (rdEn),
      .regAddr (regAddr)
   );

   // software-visible settings; the delays are raw counts of ref_clk cycles
   logic [7:0]        cfg_r;
   logic [31:0]       delay1_r;
   logic [31:0]       delay2_r;

   // interrupt status and mask share one bit layout
   logic [IRQ_W-1:0]  irqSts_r;
   logic [IRQ_W-1:0]  irqMsk_r;

   // control strobes; activation lasts exactly one cycle after its write
   logic              activatePulse_r;
   logic              swStop_r;

   // sequencer state and what software can read back about the last stop
   stop_state_e       state_r;
   stop_state_e       state_nxt;
   logic              latched_r;
   logic [1:0]        curCat_r;

   // configuration and control writes; activation is a one-cycle pulse
   // swStop stays set until software writes it back to zero
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_r           <= CFG_RESET;
         delay1_r        <= DELAY1_RESET;
         delay2_r        <= DELAY2_RESET;
         irqMsk_r        <= '0;
         activatePulse_r <= 1'b0;
         swStop_r        <= 1'b0;
      end else begin
         activatePulse_r <= 1'b0;
         if (wrEn) begin
            case (regAddr)
               CTRL_OFS: begin
                  activatePulse_r <= hwdata[CTRL_ACTIVATE_BIT];
                  swStop_r        <= hwdata[CTRL_SWSTOP_BIT];
               end
               CFG_OFS:     cfg_r    <= hwdata[7:0];
               DELAY1_OFS:  delay1_r <= hwdata;
               DELAY2_OFS:  delay2_r <= hwdata;
               IRQ_MSK_OFS: irqMsk_r <= hwdata[IRQ_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // read mux; unmapped addresses read zero
   // loaded from the address phase, so the data phase needs no wait state
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         hrdata <= 32'h0;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            CTRL_OFS:    hrdata <= {30'h0, swStop_r, 1'b0};
            CFG_OFS:     hrdata <= {24'h0, cfg_r};
            DELAY1_OFS:  hrdata <= delay1_r;
            DELAY2_OFS:  hrdata <= delay2_r;
            STATUS_OFS:  hrdata <= {24'h0, latched_r, curCat_r, 2'h0, 3'(state_r)};
            IRQ_STS_OFS: hrdata <= {28'h0, irqSts_r};
            IRQ_MSK_OFS: hrdata <= {28'h0, irqMsk_r};
            default:     hrdata <= 32'h0;
         endcase
      end
   end

   // zero wait states, always OKAY
   // kept as flops so that every top-level output leaves a register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request arbitration

   // most severe wins
   // merge one request into the running most-severe category; the codes are
   // ordered by severity, so the smaller code is the harsher stop
   function automatic logic [1:0] worst(input logic [1:0] a, input logic [1:0] b);
      worst = (b < a) ? b : a;
   endfunction

   // a configured category of 3 is treated as category 1
   function automatic logic [1:0] cfgCat(input logic [1:0] c);
      cfgCat = (c == CAT_NONE) ? CAT1 : c;
   endfunction

   // emergency inputs never use category 2; a configured 2 or 3 acts as category 1
   function automatic logic [1:0] emsCat(input logic [1:0] c);
      emsCat = (c == CAT0) ? CAT0 : CAT1;
   endfunction

   // most severe category requested this cycle, CAT_NONE when all is clear
   logic [1:0] reqCat;
   logic       emsActive;

   // each input folds its category in; the order of the tests does not matter
   always_comb begin
      reqCat = CAT_NONE;
      if (safetyIn.faultDetected) reqCat = worst(reqCat, CAT0);
      if (safetyIn.pendantEmergencyInput)
         reqCat = worst(reqCat, emsCat(cfg_r[CFG_EMS_PEND_POS +: 2]));
      if (safetyIn.externalEmergencyInput)
         reqCat = worst(reqCat, emsCat(cfg_r[CFG_EMS_EXT_POS +: 2]));
      if (safetyIn.protectiveStopInput)
         reqCat = worst(reqCat, cfgCat(cfg_r[CFG_PROT_POS +: 2]));
      if (safetyIn.hardGuardInput) reqCat = worst(reqCat, CAT0);
      if (safetyIn.softGuardInput) reqCat = worst(reqCat, CAT2);
      if (safetyIn.limitViolation)
         reqCat = worst(reqCat, cfgCat(cfg_r[CFG_LIM_POS +: 2]));
      // software stop from the control register acts as category 1
      if (swStop_r) reqCat = worst(reqCat, CAT1);
   end

   // only marks a stop as an emergency one in the status word
   assign emsActive = safetyIn.pendantEmergencyInput || safetyIn.externalEmergencyInput;

   ////////////////////////////////////////////////////////////////////////////
   // stop sequencer

   // one timer serves both timed stops; only one of them can run at a time
   logic timerLoad;
   logic timerExpired;
   logic [31:0] timerValue;

   stop_delay_timer u_timer (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .load      (timerLoad),
      .loadValue (timerValue),
      .expired   (timerExpired)
   );

   // movement seen while holding; the drives are still powered then
   logic escalate;
   assign escalate = (state_r == ST_HOLD) && safetyIn.positionChanged;

   // next state: every powered state keeps watching for a harsher request
   always_comb begin
      state_nxt  = state_r;
      timerLoad  = 1'b0;
      timerValue = delay1_r;
      case (state_r)
         ST_OFF: begin
            // activation needed
            // a request still standing makes the activation write count for nothing
            if (activatePulse_r && reqCat == CAT_NONE) state_nxt = ST_RUN;
         end
         ST_RUN: begin
            // immediate power cut
            // category 0 needs no timer, power goes at the next edge
            if (reqCat == CAT0) begin
               state_nxt = ST_OFF;
            end else if (reqCat == CAT1) begin
               state_nxt = ST_DECEL1;
               timerLoad = 1'b1;
            end else if (reqCat == CAT2) begin
               state_nxt  = ST_DECEL2;
               timerLoad  = 1'b1;
               timerValue = delay2_r;
            end
         end
         ST_DECEL1: begin
            // a milder request cannot cut a running power-cut stop short
            if (reqCat == CAT0) state_nxt = ST_OFF;
            else if (timerExpired) state_nxt = ST_OFF;
         end
         ST_DECEL2: begin
            if (reqCat == CAT0) begin
               state_nxt = ST_OFF;
            end else if (reqCat == CAT1) begin
               // harsher request restarts with the category 1 delay
               state_nxt = ST_DECEL1;
               timerLoad = 1'b1;
            end else if (timerExpired) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (escalate || reqCat == CAT0) begin
               state_nxt = ST_OFF;
            end else if (reqCat == CAT1) begin
               state_nxt = ST_DECEL1;
               timerLoad = 1'b1;
            end else if (reqCat == CAT_NONE) begin
               // resume without activation
               // a standing category 2 request keeps the hold instead
               state_nxt = ST_RUN;
            end
         end
         default: state_nxt = ST_OFF;
      endcase
   end

   // state register; power is off from reset until software activates
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // remember the category and whether an emergency caused the stop
   // escalation from hold is recorded as category 0 whatever was requested
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         curCat_r  <= CAT_NONE;
         latched_r <= 1'b0;
      end else if (state_nxt == ST_RUN) begin
         curCat_r  <= CAT_NONE;
         latched_r <= 1'b0;
      end else if (state_r != state_nxt) begin
         curCat_r  <= escalate ? CAT0 : worst(reqCat, curCat_r);
         latched_r <= latched_r || emsActive;
      end
   end

   // drive outputs registered from the next state
   // this keeps the power cut on the same edge as the state change
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         driveOut <= '0;
      end else begin
         driveOut.motorPowerEn    <= (state_nxt != ST_OFF);
         driveOut.decelCmd        <= (state_nxt == ST_DECEL1) || (state_nxt == ST_DECEL2);
         driveOut.holdSupervision <= (state_nxt == ST_HOLD);
         driveOut.motionAllowed   <= (state_nxt == ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: set wins over write-one-to-clear

   logic [IRQ_W-1:0] irqSet;

   // true on the cycle that moves the sequencer into state s from elsewhere
   function automatic logic entering(input stop_state_e cur, input stop_state_e nxt,
                                     input stop_state_e s);
      entering = (cur != s) && (nxt == s);
   endfunction

   // events are edges of the sequencer, so a held request raises each only once
   always_comb begin
      irqSet = '0;
      irqSet[IRQ_CAT0_BIT]  = entering(state_r, state_nxt, ST_OFF);
      irqSet[IRQ_CAT1_BIT]  = entering(state_r, state_nxt, ST_DECEL1);
      irqSet[IRQ_CAT2_BIT]  = entering(state_r, state_nxt, ST_DECEL2);
      irqSet[IRQ_ESCAL_BIT] = escalate;
   end

   // write-one-to-clear; an event in the clearing cycle is kept
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irqSts_r <= '0;
      end else begin
         if (wrEn && regAddr == IRQ_STS_OFS) begin
            irqSts_r <= (irqSts_r & ~hwdata[IRQ_W-1:0]) | irqSet;
         end else begin
            irqSts_r <= irqSts_r | irqSet;
         end
      end
   end

   // includes this cycle's events so irq rises with the status bit, not later
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irqSts_r | irqSet) & irqMsk_r);
      end
   end

endmodule

// *** tb/safety_stop_chk.sv ***
// port checker for the stop sequencer
// assumes one clock domain; bound from the bench top file
`timescale 1ns/1ps
module safety_stop_chk
   import safety_stop_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        resetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // safety side
   input wire safety_in_s  safetyIn,
   input wire drive_out_s  driveOut,
   input wire logic        irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   logic       ctrlWr_r;
   logic [2:0] actCnt_r;

   // remember an activation write a few cycles, since power may rise only after one
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrlWr_r <= 1'b0;
         actCnt_r <= 3'h0;
      end else begin
         ctrlWr_r <= hready & hsel & htrans[1] & hwrite & (haddr[7:0] == CTRL_OFS);
         if (ctrlWr_r && hready && hwdata[CTRL_ACTIVATE_BIT]) actCnt_r <= 3'h7;
         else if (actCnt_r != 3'h0) actCnt_r <= actCnt_r - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_fault_cut: assert property (safetyIn.faultDetected |-> ##[1:4] !driveOut.motorPowerEn)
      else $error("power still on after fault");
   a_guard_cut: assert property (safetyIn.hardGuardInput |-> ##[1:4] !driveOut.motorPowerEn)
      else $error("power still on after hard guard");
   a_cat0_direct: assert property ((safetyIn == 8'h80) && ($past(safetyIn) == 8'h00)
      && driveOut.motionAllowed |-> (!driveOut.decelCmd) [*4])
      else $error("deceleration seen in torque-off stop");
   a_act_gate: assert property ($rose(driveOut.motorPowerEn) |-> actCnt_r != 3'h0)
      else $error("power rose without activation");
   a_decel_power: assert property (driveOut.decelCmd
      |-> driveOut.motorPowerEn && !driveOut.motionAllowed)
      else $error("decel without power or with motion");
   a_hold_power: assert property (driveOut.holdSupervision
      |-> driveOut.motorPowerEn && !driveOut.decelCmd)
      else $error("hold without power");
   a_hold_escal: assert property (driveOut.holdSupervision && safetyIn.positionChanged
      |-> ##[1:4] !driveOut.motorPowerEn)
      else $error("no escalation on movement in hold");
   a_soft_decel: assert property ((safetyIn == 8'h04) && ($past(safetyIn) == 8'h00)
      && driveOut.motionAllowed |-> ##[1:4] driveOut.decelCmd)
      else $error("soft guard did not decelerate");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");

   c_hold: cover property (driveOut.holdSupervision);
   c_power_up: cover property ($rose(driveOut.motorPowerEn));
   c_decel_cut: cover property (driveOut.decelCmd ##1 !driveOut.motorPowerEn);
endmodule

// *** tb/joint_drive_model.sv ***
// joint drive and encoder stand-in reporting arm movement
// assumes pushArm is an outside force applied by the bench
`timescale 1ns/1ps
module joint_drive_model
   import safety_stop_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // commands and outside force
   input  wire drive_out_s driveOut,
   input  wire logic       pushArm,
   // encoder report
   output logic            positionChanged
);
   // a push shows only on joints not being driven; a moving arm hides it
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) positionChanged <= 1'b0;
      else positionChanged <= pushArm & ~driveOut.motionAllowed;
   end
endmodule

// *** tb/safety_stop_category_controller_tb.sv ***
// bench: bus tasks, a table of stop requests, hold escalation
// assumes a zero-wait slave; the joint model feeds positionChanged
`timescale 1ns/1ps
module safety_stop_category_controller_tb
   import safety_stop_pkg::*;
;
   localparam int DLY = 5;
   localparam int POW = 3;
   localparam int DEC = 2;
   localparam int HLD = 1;
   localparam int MOV = 0;
   localparam logic [7:0] STIM [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02,
      8'h84, 8'h14};
   localparam logic [1:0] CATS [9] = '{CAT0, CAT0, CAT1, CAT1, CAT0, CAT2, CAT2, CAT0, CAT1};

   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        pushArm = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0]  inBits = 8'h00;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   logic        posChg;
   logic [3:0]  dv;
   logic [3:0]  irqExp;
   drive_out_s  driveOut;
   safety_in_s  safetyIn;
   int          fails = 0;
   int          cmpCount = 0;
   int          n;

   assign safetyIn = {inBits[7:1], posChg};
   assign dv = driveOut;

   // free-running 20 MHz clock
   always #25 ref_clk = ~ref_clk;

   safety_stop_category_controller dut_u (
      .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .safetyIn(safetyIn), .driveOut(driveOut),
      .irq(irq));
   joint_drive_model drv_u (.ref_clk(ref_clk), .resetn(resetn), .driveOut(driveOut),
      .pushArm(pushArm), .positionChanged(posChg));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one single-word transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // bounded wait for one drive command bit; n holds the cycles spent
   task automatic waitOut(input int b, input logic v);
      n = 0;
      while (dv[b] !== v && n < 60) begin
         @(posedge ref_clk);
         n++;
      end
      // a wait that runs out shows up as a mismatch
      chk(32'(dv[b]), 32'(v));
   endtask

   task automatic close_out();
      $display("fails=%0d compares=%0d", fails, cmpCount);
      if (fails == 0 && cmpCount > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // hang guard, far beyond the expected run of about three hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      close_out();
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      chk(32'(dv), 32'h0);
      bus(1'b0, CFG_OFS, 32'h0);
      chk(rd, 32'(CFG_RESET));
      bus(1'b0, DELAY1_OFS, 32'h0);
      chk(rd, DELAY1_RESET);
      bus(1'b0, 8'h1C, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, CFG_OFS, 32'h94);
      bus(1'b1, DELAY1_OFS, 32'(DLY));
      bus(1'b1, DELAY2_OFS, 32'(DLY));
      bus(1'b1, IRQ_MSK_OFS, 32'hF);
      // each row: run, request, watch the stop, refused activation, release
      for (int i = 0; i < 9; i++) begin
         irqExp = (CATS[i] == CAT0) ? 4'h1 : (CATS[i] == CAT1) ? 4'h3 : 4'h4;
         bus(1'b1, CTRL_OFS, 32'h1);
         waitOut(MOV, 1'b1);
         inBits <= STIM[i];
         waitOut(MOV, 1'b0);
         chk(32'(dv[POW:DEC]), (CATS[i] == CAT0) ? 32'h0 : 32'h3);
         if (CATS[i] != CAT0) begin
            waitOut(DEC, 1'b0);
            chk(32'(n >= DLY - 1 && n <= DLY + 2), 32'h1);
            chk(32'(dv[POW:HLD]), (CATS[i] == CAT2) ? 32'h5 : 32'h0);
         end
         bus(1'b0, STATUS_OFS, 32'h0);
         chk(32'(rd[6:5]), 32'(CATS[i]));
         bus(1'b0, IRQ_STS_OFS, 32'h0);
         chk(32'(rd[3:0]), 32'(irqExp));
         chk(32'(irq), 32'h1);
         bus(1'b1, IRQ_STS_OFS, 32'hF);
         bus(1'b1, CTRL_OFS, 32'h1);
         // keep the request up while the activation pulse is live
         @(posedge ref_clk);
         inBits <= 8'h00;
         repeat (8) @(posedge ref_clk);
         chk(32'(dv[MOV]), 32'(CATS[i] == CAT2));
         chk(32'(irq), 32'h0);
      end
      // movement while holding must cut power; masked event leaves irq low
      bus(1'b1, IRQ_MSK_OFS, 32'h0);
      bus(1'b1, CTRL_OFS, 32'h1);
      waitOut(MOV, 1'b1);
      inBits <= 8'h04;
      waitOut(HLD, 1'b1);
      pushArm <= 1'b1;
      @(posedge ref_clk);
      pushArm <= 1'b0;
      waitOut(POW, 1'b0);
      chk(32'(n < 6), 32'h1);
      bus(1'b0, IRQ_STS_OFS, 32'h0);
      chk(32'(rd[IRQ_ESCAL_BIT]), 32'h1);
      chk(32'(irq), 32'h0);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk(32'(rd[6:5]), 32'(CAT0));
      // software stop acts as category 1 and reads back from the control word
      inBits <= 8'h00;
      bus(1'b1, CTRL_OFS, 32'h1);
      waitOut(MOV, 1'b1);
      bus(1'b1, CTRL_OFS, 32'h2);
      waitOut(POW, 1'b0);
      chk(32'(n >= DLY), 32'h1);
      bus(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'h2);
      bus(1'b1, CTRL_OFS, 32'h0);
      close_out();
   end
endmodule

bind safety_stop_category_controller safety_stop_chk chk_u (
   .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .safetyIn(safetyIn), .driveOut(driveOut),
   .irq(irq));
